// File: rtl/tcc_defs.svh
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// register indexes on the plain register port
`define TCC_ADDR_CFG   4'h0
`define TCC_ADDR_CTLA  4'h1
`define TCC_ADDR_CTLB  4'h2
`define TCC_ADDR_VALL  4'h3
`define TCC_ADDR_VALH  4'h4
`define TCC_ADDR_RLDL  4'h5
`define TCC_ADDR_RLDH  4'h6
`define TCC_ADDR_CMPL  4'h7
`define TCC_ADDR_CMPH  4'h8

// reset values
`define TCC_RST_CFG    8'h00
`define TCC_RST_CTLA   8'h00
`define TCC_RST_CTLB   8'h00
`define TCC_RST_WORD   16'h0000

// flag field positions in timer_control_b
`define TCC_B_OVF      3
`define TCC_B_LOVF     2
`define TCC_B_CCF      1
`define TCC_B_LCF      0

// overflow points of the counters
`define TCC_TOP16      16'hFFFF
`define TCC_TOP8       8'hFF

// alternate clock: least system clock is four times its rate
`define TCC_ALT_HZ     32000
`define TCC_CLK_HZ     100000000
`define TCC_ALT_RATIO  4

`endif

// File: rtl/tcc_pkg.sv
package tcc_pkg;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_WAIT = 2'b01,
    CAP_RUN  = 2'b10
  } tcc_cap_state_t;

  typedef struct packed {
    logic       alt_clock_select;
    logic [2:0] prescale_field;
    logic       width_mode;
    logic [1:0] function_edge_field;
    logic       count_or_time_select;
  } tcc_cfg_t;

  typedef struct packed {
    logic       run_bit;
    logic       single_shot;
    logic       output_enable0;
    logic       output_polarity0;
    logic       capture_reload_bit;
    logic [1:0] rsvd;
    logic       gate_enable;
  } tcc_ctla_t;

  typedef struct packed {
    logic       low_half_irq_enable;
    logic       output_enable1;
    logic       output_polarity1;
    logic       rsvd;
    logic       overflow_flag;
    logic       low_overflow_flag;
    logic       capture_compare_flag;
    logic       low_compare_flag;
  } tcc_ctlb_t;

endpackage

// File: rtl/tcc_tick_gen.sv
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_tick_gen #(
  parameter int PRE_W = 7
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       alt_sel,
  input  wire logic [2:0] div_sel,
  input  wire logic       alt_clk,
  output logic            tick
);
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] mask;
  logic             alt_s1_q;
  logic             alt_s2_q;
  logic             alt_s3_q;

  // free-running prescaler; a power-of-two ratio is a mask on its low bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  assign mask = PRE_W'((8'h01 << div_sel) - 8'h01); // R3

  // alternate clock synchroniser; s1 feeds only s2 to contain metastability
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alt_s1_q <= 1'b0;
      alt_s2_q <= 1'b0;
      alt_s3_q <= 1'b0;
    end else begin
      alt_s1_q <= alt_clk; // R2
      alt_s2_q <= alt_s1_q;
      alt_s3_q <= alt_s2_q;
    end
  end

  // sampling loses edges if the system clock is below four times the rate
  assign tick = alt_sel ? (alt_s2_q & !alt_s3_q)   // R1
                        : ((pre_q & mask) == mask); // R3

  ratio_two_a: assert property (@(posedge clk) disable iff (!nrst) // R3
    (!alt_sel && div_sel == 3'h1 && tick) |=>
      (alt_sel || div_sel != 3'h1 || !tick))
    else $error("divide by two ticked twice in a row");

  alt_edge_a: assert property (@(posedge clk) disable iff (!nrst) // R1
    (alt_sel && tick) |-> ($past(alt_clk, 2) && !$past(alt_clk, 3)))
    else $error("alternate tick without a sampled rising edge");
endmodule

// File: rtl/tcc_timer.sv
// Function
// R1: alt select bit picks 32kHz clock
// R2: alternate clock sampled by system clock
// R3: divide field sets power-of-two prescale
// R4: width mode picks 16-bit or dual 8-bit
// R5: function field with select sets mode
// R6: counter mode counts chosen external edges
// R7: compare single shot emits one cycle
// R8: no gated single shot in dual mode; code exempts only compare single shot, capture single shot stays gated
// R9: capture single shot waits for start edge
// R10: single shot alone runs one capture
// R11: polarity bit picks both-edge start edge
// R12: start edge sets no flag
// R13: primary pin gates high or 16-bit timer
// R14: both-edge reload suppressed on one edge
// R15: low enable gates low flag requests
// R16: single-pin build lacks secondary enable
// R17: secondary polarity applies on enable rise
// R18: overflow flag on main counter overflow
// R19: low overflow flag on low overflow
// R20: compare flag on match or capture
// R21: low compare flag only in dual
// R22: polarity XORs the toggling output
// R23: overflow loads the reload pair
// R24: single shot clears at ending reload
// R25: flags stay until software writes zero
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_timer
  import tcc_pkg::*;
#(
  parameter bit DUAL_PIN = 1'b1
) (
  input  wire logic       CORE_CLK,
  input  wire logic       NRST,
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       ALT_CLK,
  input  wire logic       PRIMARY_PIN_I,
  output logic            PRIMARY_PIN_O,
  output logic            PRIMARY_PIN_OE_N,
  output logic            SECONDARY_PIN_O,
  output logic            SECONDARY_PIN_OE_N,
  output logic            LOW_IRQ,
  output logic            TIMER_REQ
);
  tcc_cfg_t       cfg_q;
  tcc_ctla_t      cta_q;
  tcc_ctlb_t      ctb_q;
  tcc_cap_state_t cap_q;
  logic [15:0]    val_q;
  logic [15:0]    val_d;
  logic [15:0]    rld_q;
  logic [15:0]    cmp_q;
  logic [7:0]     rdata_q;
  logic           pin_q;
  logic           wave_hi_q;
  logic           wave_lo_q;
  logic [1:0]     oe_q;
  logic [1:0]     pol_q;
  logic           pin0_q;
  logic           pin1_q;
  logic           tick;
  logic           wr_cfg;
  logic           wr_cta;
  logic           wr_ctb;
  logic           dual;
  logic           ctr_mode;
  logic           cmp_mode;
  logic           cap_mode;
  logic           both;
  logic           rise;
  logic           fall;
  logic           sel_edge;
  logic           ss_edge;
  logic           gate_req;
  logic           gated;
  logic           gate_hold;
  logic           run_hi;
  logic           tick_hi;
  logic           tick_lo;
  logic           ovf_hi;
  logic           ovf_lo;
  logic           match_hi;
  logic           match_lo;
  logic           top_match;
  logic           cap_ev;
  logic           cap_rld;
  logic           cap_end;
  logic           oe1_w;

  // clock source and prescaler
  tcc_tick_gen #(
    .PRE_W (7)
  ) u_tick (
    .clk     (CORE_CLK),
    .nrst    (NRST),
    .alt_sel (cfg_q.alt_clock_select), // R1
    .div_sel (cfg_q.prescale_field),   // R3
    .alt_clk (ALT_CLK),                // R2
    .tick    (tick)
  );

  // register write decode
  assign wr_cfg = REG_WR && REG_ADDR == `TCC_ADDR_CFG;
  assign wr_cta = REG_WR && REG_ADDR == `TCC_ADDR_CTLA;
  assign wr_ctb = REG_WR && REG_ADDR == `TCC_ADDR_CTLB;

  // mode decode
  assign dual     = cfg_q.width_mode; // R4
  assign ctr_mode = cfg_q.count_or_time_select;
  assign cmp_mode = !ctr_mode && cfg_q.function_edge_field == 2'b00; // R5
  assign cap_mode = !ctr_mode && cfg_q.function_edge_field != 2'b00; // R5
  assign both     = cfg_q.function_edge_field == 2'b11;

  // pin edges; the pin is taken as synchronous to the core clock
  assign rise     = PRIMARY_PIN_I && !pin_q;
  assign fall     = !PRIMARY_PIN_I && pin_q;
  assign sel_edge = (cfg_q.function_edge_field[0] && rise) ||
                    (cfg_q.function_edge_field[1] && fall);
  assign ss_edge  = both ? (cta_q.output_polarity0 ? fall : rise) // R11
                         : sel_edge;

  // gating: pin is an input only with primary output off, timer mode
  assign gate_req  = cta_q.gate_enable && !cta_q.output_enable0 &&
                     !ctr_mode && !(both && cta_q.capture_reload_bit); // R13
  assign gated     = gate_req &&
                     PRIMARY_PIN_I == cta_q.output_polarity0; // R13
  // a compare single shot in dual mode ignores the gate
  assign gate_hold = gated && !(dual && cta_q.single_shot && cmp_mode); // R8

  // run condition of the 16-bit or high timer
  always_comb begin
    if (cap_mode) begin
      run_hi = (cta_q.run_bit && cap_q == CAP_IDLE) || cap_q == CAP_RUN; // R10
    end else begin
      run_hi = cta_q.run_bit || (cmp_mode && cta_q.single_shot); // R7
    end
  end

  assign tick_hi = ctr_mode
    ? (cta_q.run_bit && cfg_q.function_edge_field != 2'b00 && sel_edge) // R6
    : (tick && run_hi && !gate_hold); // R13
  // low half: internal clock, compare only, never gated
  assign tick_lo = dual && tick &&
                   (cta_q.run_bit || cta_q.single_shot); // R4

  assign ovf_hi   = tick_hi && (dual ? val_q[15:8] == `TCC_TOP8
                                     : val_q == `TCC_TOP16); // R18
  assign ovf_lo   = tick_lo && val_q[7:0] == `TCC_TOP8; // R19
  assign match_hi = cmp_mode && tick_hi &&
                    (dual ? val_q[15:8] == cmp_q[15:8] : val_q == cmp_q);
  assign match_lo = tick_lo && val_q[7:0] == cmp_q[7:0]; // R21
  assign top_match = dual ? cmp_q[15:8] == `TCC_TOP8
                          : cmp_q == `TCC_TOP16;

  // capture events; the single-shot start edge is not one of them
  assign cap_end = cap_mode && cap_q == CAP_RUN && ss_edge;
  assign cap_ev  = cap_mode && ((cap_q == CAP_IDLE && cta_q.run_bit &&
                   sel_edge) || cap_q == CAP_RUN && ss_edge); // R12
  assign cap_rld = cap_ev && cta_q.capture_reload_bit &&
                   !(both && cta_q.gate_enable &&
                     (cta_q.output_polarity0 ? rise : fall)); // R14

  // next timer value: writes, then capture reload, then counting
  always_comb begin
    val_d = val_q;
    if (cap_rld) begin
      if (dual) begin
        val_d[15:8] = rld_q[15:8];
      end else begin
        val_d = rld_q;
      end
    end else if (tick_hi) begin
      if (dual) begin
        val_d[15:8] = ovf_hi ? rld_q[15:8] : val_q[15:8] + 8'h01; // R23
      end else begin
        val_d = ovf_hi ? rld_q : val_q + 16'h0001; // R23
      end
    end
    if (tick_lo) begin
      val_d[7:0] = ovf_lo ? rld_q[7:0] : val_q[7:0] + 8'h01; // R23
    end
    if (REG_WR && REG_ADDR == `TCC_ADDR_VALL) begin
      val_d[7:0] = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == `TCC_ADDR_VALH) begin
      val_d[15:8] = REG_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      val_q <= `TCC_RST_WORD;
    end else begin
      val_q <= val_d;
    end
  end

  // reload pair, software only
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rld_q <= `TCC_RST_WORD;
    end else if (REG_WR && REG_ADDR == `TCC_ADDR_RLDL) begin
      rld_q[7:0] <= REG_WDATA;
    end else if (REG_WR && REG_ADDR == `TCC_ADDR_RLDH) begin
      rld_q[15:8] <= REG_WDATA;
    end
  end

  // compare register doubles as capture register; capture beats a write
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cmp_q <= `TCC_RST_WORD;
    end else if (cap_ev) begin
      if (dual) begin
        cmp_q[15:8] <= val_q[15:8];
      end else begin
        cmp_q <= val_q; // R20
      end
    end else if (REG_WR && REG_ADDR == `TCC_ADDR_CMPL) begin
      cmp_q[7:0] <= REG_WDATA;
    end else if (REG_WR && REG_ADDR == `TCC_ADDR_CMPH) begin
      cmp_q[15:8] <= REG_WDATA;
    end
  end

  // configuration register
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_q <= tcc_cfg_t'(`TCC_RST_CFG);
    end else if (wr_cfg) begin
      cfg_q <= tcc_cfg_t'(REG_WDATA);
    end
  end

  // control A; a fresh single-shot write wins over the hardware clear
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cta_q <= tcc_ctla_t'(`TCC_RST_CTLA);
    end else if (wr_cta) begin
      cta_q      <= tcc_ctla_t'(REG_WDATA);
      cta_q.rsvd <= 2'b00;
    end else if ((cmp_mode && ovf_hi) || cap_end) begin
      cta_q.single_shot <= 1'b0; // R24
    end
  end

  // single-shot capture sequencer
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cap_q <= CAP_IDLE;
    end else if (!cap_mode) begin
      cap_q <= CAP_IDLE;
    end else if (wr_cta && REG_WDATA[6]) begin
      cap_q <= CAP_WAIT; // R9
    end else begin
      unique case (cap_q)
        CAP_IDLE: begin
          cap_q <= CAP_IDLE;
        end
        CAP_WAIT: begin
          if (ss_edge || (gate_req && !gated)) begin
            cap_q <= CAP_RUN; // R9
          end
        end
        CAP_RUN: begin
          if (ss_edge) begin
            cap_q <= CAP_IDLE; // R10
          end
        end
        default: begin
          cap_q <= CAP_IDLE;
        end
      endcase
    end
  end

  // secondary enable does not exist on a single-pin build
  assign oe1_w = DUAL_PIN && REG_WDATA[6]; // R16

  // control B: set wins over clear, a written one also sets
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ctb_q <= tcc_ctlb_t'(`TCC_RST_CTLB);
    end else begin
      if (wr_ctb) begin
        ctb_q.low_half_irq_enable <= REG_WDATA[7];
        ctb_q.output_enable1      <= oe1_w;
        ctb_q.output_polarity1    <= REG_WDATA[5];
      end
      ctb_q.rsvd <= 1'b0;
      ctb_q.overflow_flag <= ovf_hi ||
        (wr_ctb ? REG_WDATA[`TCC_B_OVF] : ctb_q.overflow_flag); // R25
      ctb_q.low_overflow_flag <= ovf_lo ||
        (wr_ctb ? REG_WDATA[`TCC_B_LOVF] : ctb_q.low_overflow_flag); // R19
      ctb_q.capture_compare_flag <= match_hi || cap_ev || // R20
        (wr_ctb ? REG_WDATA[`TCC_B_CCF] : ctb_q.capture_compare_flag);
      ctb_q.low_compare_flag <= (dual && match_lo) ||
        (wr_ctb ? REG_WDATA[`TCC_B_LCF] : ctb_q.low_compare_flag); // R21
    end
  end

  // waveforms toggle after a match or overflow; a match at the top of
  // the range would double the toggle, so only the overflow counts
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wave_hi_q <= 1'b0;
      wave_lo_q <= 1'b0;
    end else begin
      if (ovf_hi || (match_hi && !top_match)) begin
        wave_hi_q <= !wave_hi_q;
      end
      if (ovf_lo || (match_lo && cmp_q[7:0] != `TCC_TOP8)) begin
        wave_lo_q <= !wave_lo_q;
      end
    end
  end

  // polarity is latched only when the output enable rises
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      oe_q  <= 2'b00;
      pol_q <= 2'b00;
    end else begin
      oe_q <= {ctb_q.output_enable1, cta_q.output_enable0};
      if (cta_q.output_enable0 && !oe_q[0]) begin
        pol_q[0] <= cta_q.output_polarity0; // R22
      end
      if (ctb_q.output_enable1 && !oe_q[1]) begin
        pol_q[1] <= ctb_q.output_polarity1; // R17
      end
    end
  end

  // pin drivers; the secondary pin follows the low timer in dual mode
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      pin_q  <= 1'b0;
      pin0_q <= 1'b0;
      pin1_q <= 1'b0;
    end else begin
      pin_q  <= PRIMARY_PIN_I;
      pin0_q <= wave_hi_q ^ pol_q[0]; // R22
      pin1_q <= (dual ? wave_lo_q : wave_hi_q) ^ pol_q[1]; // R17
    end
  end

  assign PRIMARY_PIN_O      = pin0_q;
  assign PRIMARY_PIN_OE_N   = !oe_q[0];
  assign SECONDARY_PIN_O    = pin1_q;
  assign SECONDARY_PIN_OE_N = !oe_q[1];

  // requests: the low half has its own enable, the upper flags do not
  assign LOW_IRQ   = ctb_q.low_half_irq_enable &&
                     (ctb_q.low_overflow_flag || ctb_q.low_compare_flag); // R15
  assign TIMER_REQ = ctb_q.overflow_flag || ctb_q.capture_compare_flag;

  // read port: data in the cycle after the strobe, unmapped reads zero
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `TCC_ADDR_CFG:  rdata_q <= cfg_q;
        `TCC_ADDR_CTLA: rdata_q <= cta_q;
        `TCC_ADDR_CTLB: rdata_q <= ctb_q;
        `TCC_ADDR_VALL: rdata_q <= val_q[7:0];
        `TCC_ADDR_VALH: rdata_q <= val_q[15:8];
        `TCC_ADDR_RLDL: rdata_q <= rld_q[7:0];
        `TCC_ADDR_RLDH: rdata_q <= rld_q[15:8];
        `TCC_ADDR_CMPL: rdata_q <= cmp_q[7:0];
        `TCC_ADDR_CMPH: rdata_q <= cmp_q[15:8];
        default:        rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign REG_RDATA = rdata_q;

  ovf_flag_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R18
    ovf_hi |=> ctb_q.overflow_flag)
    else $error("overflow did not set the overflow flag");

  reload_load_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R23
    (ovf_hi && !dual && !cap_rld && !REG_WR) |=> val_q == $past(rld_q))
    else $error("overflow did not load the reload pair");

  ss_clear_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R24
    (cmp_mode && ovf_hi && !wr_cta) |=> !cta_q.single_shot)
    else $error("single shot not cleared at overflow");

  cap_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R9
    (cap_q == CAP_WAIT && cap_mode && !REG_WR) |=> $stable(val_q[15:8]))
    else $error("timer moved while waiting for start edge");

  start_noflag_a: assert property (@(posedge CORE_CLK) // R12
    disable iff (!NRST)
    (cap_q == CAP_WAIT && cap_mode && ss_edge && !wr_ctb && !wr_cta &&
     !ctb_q.capture_compare_flag) |=>
      (cap_q == CAP_RUN && !ctb_q.capture_compare_flag))
    else $error("start edge set a flag or did not start");

  capture_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R20
    (cap_ev && !dual) |=>
      (ctb_q.capture_compare_flag && cmp_q == $past(val_q)))
    else $error("capture did not store value and flag");

  gate_block_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R13
    (gated && !dual && !ctr_mode) |-> !tick_hi)
    else $error("gated timer still counted");

  low_cmp_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R21
    (match_lo && dual && ctb_q.low_half_irq_enable && !wr_ctb) |=>
      (ctb_q.low_compare_flag && LOW_IRQ))
    else $error("low compare did not flag or request");

  pol_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R17
    (oe_q[1] && $past(oe_q[1]) && ctb_q.output_enable1 && !dual &&
     $stable(dual) && $stable(wave_hi_q)) |=>
      $stable(SECONDARY_PIN_O))
    else $error("polarity change reached pin without enable rise");
endmodule

// File: testbench/tcc_pin_model.sv
`timescale 1ns/1ps
// outside world on the primary pin: a level source behind the shared line
module tcc_pin_model (
  input  wire logic CORE_CLK,
  input  wire logic PIN_O,
  input  wire logic PIN_OE_N,
  output logic      PIN_I
);
  logic ext_q;

  // the line follows the timer while it drives, else the outside level
  assign PIN_I = PIN_OE_N ? ext_q : PIN_O;

  initial ext_q = 1'b0;

  // levels move just after an edge, so the timer never sees a race
  task automatic drive(input logic v);
    @(posedge CORE_CLK);
    ext_q <= v;
  endtask
endmodule

// File: testbench/tcc_timer_tb.sv
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_timer_tb;
  logic       clk, nrst, wr_s, rd_s, alt;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rd;
  logic       pin_i, pin_o, pin_oe_n, sec_o, sec_oe_n, low_irq, treq;
  int         n_fail, checked, p, exp_cnt[4];
  time        t;

  // system clock; alternate clock is a fortieth of it
  always #5 clk = ~clk;
  always #200 alt = ~alt;

  tcc_timer i_dut (
    .CORE_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .ALT_CLK(alt),
    .PRIMARY_PIN_I(pin_i), .PRIMARY_PIN_O(pin_o),
    .PRIMARY_PIN_OE_N(pin_oe_n), .SECONDARY_PIN_O(sec_o),
    .SECONDARY_PIN_OE_N(sec_oe_n), .LOW_IRQ(low_irq), .TIMER_REQ(treq));

  tcc_pin_model i_pins (
    .CORE_CLK(clk), .PIN_O(pin_o), .PIN_OE_N(pin_oe_n), .PIN_I(pin_i));

  // one-cycle register strobes
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
    #1; // callers look at the result once the write edge has settled
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 rd = rdata;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // bounded wait: 0 request, 1 low irq, 2 primary pin low
  task automatic wait_hi(input int sel, output time tt);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 && treq === 1'b1) || (sel == 1 && low_irq === 1'b1)
          || (sel == 2 && pin_o === 1'b0)) break;
    end
    if (i == 3000) begin
      n_fail++;
      report_and_stop();
    end
    tt = $time;
  endtask

  // first rise may be a partial period, so time the next two
  task automatic period(input int sel, input logic [7:0] clr);
    time t1;
    time t2;
    wait_hi(sel, t1);
    wr(`TCC_ADDR_CTLB, clr);
    wait_hi(sel, t1);
    wr(`TCC_ADDR_CTLB, clr);
    wait_hi(sel, t2);
    p = int'((t2 - t1) / 10);
  endtask

  task automatic set16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask

  initial begin
    clk = 0; alt = 0; nrst = 0; wr_s = 0; rd_s = 0; addr = 0; wdata = 0;
    n_fail = 0; checked = 0; exp_cnt = '{0, 5, 5, 10};
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // reset state, unmapped indexes included
    chk("pin oe", {pin_oe_n, sec_oe_n, low_irq, treq}, 16'hC);
    for (int a = 0; a < 16; a++) begin
      rdr(a[3:0]);
      chk("reset", rd, 0);
    end
    wr(4'hF, 8'hFF);
    rdr(4'hF);
    chk("unmapped", rd, 0);
    wr(`TCC_ADDR_CFG, 8'hFF);
    rdr(`TCC_ADDR_CFG);
    chk("cfg", rd, 8'hFF);
    wr(`TCC_ADDR_CFG, 8'h00);
    // secondary level only follows polarity on an enable rise
    wr(`TCC_ADDR_CTLB, 8'h70);
    rdr(`TCC_ADDR_CTLB);
    chk("ctlb", rd, 8'h60);
    chk("sec start", {sec_oe_n, sec_o}, 2'b01);
    wr(`TCC_ADDR_CTLB, 8'h40);
    repeat (3) @(posedge clk);
    chk("sec hold", sec_o, 1);
    wr(`TCC_ADDR_CTLB, 8'h00);
    wr(`TCC_ADDR_CTLB, 8'h40);
    repeat (3) @(posedge clk);
    chk("sec new", sec_o, 0);
    // flags set by software, masked low request, cleared by zero
    wr(`TCC_ADDR_CTLB, 8'h0F);
    chk("req", {low_irq, treq}, 2'b01);
    wr(`TCC_ADDR_CTLB, 8'h8F);
    chk("low req", low_irq, 1);
    wr(`TCC_ADDR_CTLB, 8'h80);
    rdr(`TCC_ADDR_CTLB);
    chk("clear", {rd, low_irq, treq}, 16'h200);
    // prescale sweep: four ticks from reload to overflow
    set16(`TCC_ADDR_RLDL, 16'hFFFC);
    set16(`TCC_ADDR_VALL, 16'hFFFC);
    set16(`TCC_ADDR_CMPL, 16'h00FE);
    wr(`TCC_ADDR_CTLA, 8'h80);
    for (int d = 0; d < 8; d++) begin
      wr(`TCC_ADDR_CFG, {1'b0, d[2:0], 4'h0});
      period(0, 8'h00);
      chk("prescale", 16'(p), 16'(4 << d));
    end
    rdr(`TCC_ADDR_CTLB);
    chk("no low cmp", rd & 8'h03, 0);
    wr(`TCC_ADDR_CFG, 8'hF0);
    period(0, 8'h00);
    chk("alt clock", 16'(p), 16'd160);
    wr(`TCC_ADDR_CTLA, 8'h00);
    rdr(`TCC_ADDR_VALH);
    chk("reloaded", rd, 8'hFF);
    // dual mode: low byte wraps on its own, high byte far from events
    wr(`TCC_ADDR_CFG, 8'h28);
    set16(`TCC_ADDR_VALL, 16'h00FC);
    set16(`TCC_ADDR_RLDL, 16'h00FC);
    set16(`TCC_ADDR_CMPL, 16'h8000);
    wr(`TCC_ADDR_CTLB, 8'h80);
    wr(`TCC_ADDR_CTLA, 8'h80);
    period(1, 8'h80);
    chk("low period", 16'(p), 16'd16);
    rdr(`TCC_ADDR_CTLB);
    chk("high quiet", rd & 8'h0A, 0);
    wr(`TCC_ADDR_CMPL, 8'hFE);
    repeat (20) @(posedge clk);
    rdr(`TCC_ADDR_CTLB);
    chk("low cmp", {rd[0], low_irq}, 2'b11);
    wr(`TCC_ADDR_CTLA, 8'h00);
    wr(`TCC_ADDR_CFG, 8'h00);
    // second reset with the timer stopped brings enables and requests back to reset
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk("rerun", {pin_oe_n, sec_oe_n, low_irq, treq}, 16'hC);
    // compare single shot on the primary pin, high start
    set16(`TCC_ADDR_RLDL, 16'hFFF0);
    set16(`TCC_ADDR_VALL, 16'hFFF0);
    set16(`TCC_ADDR_CMPL, 16'hFFF8);
    wr(`TCC_ADDR_CTLB, 8'h00);
    wr(`TCC_ADDR_CTLA, 8'h30);
    repeat (3) @(posedge clk);
    chk("pwm start", {pin_oe_n, pin_o}, 2'b01);
    wr(`TCC_ADDR_CTLA, 8'h70);
    wait_hi(2, t);
    for (int i = 0; i < 100; i++) begin
      rdr(`TCC_ADDR_CTLA);
      if (rd[6] === 1'b0) break;
    end
    chk("ss clear", rd, 8'h30);
    rdr(`TCC_ADDR_CTLB);
    chk("ss flags", rd & 8'h0A, 8'h0A);
    rdr(`TCC_ADDR_VALL);
    p = rd;
    repeat (10) @(posedge clk);
    rdr(`TCC_ADDR_VALL);
    chk("ss stopped", {rd, pin_o}, {p[7:0], 1'b1});
    // edge counting for every function code, five full pulses each
    wr(`TCC_ADDR_CTLA, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(`TCC_ADDR_CFG, {5'h0, c[1:0], 1'b1});
      wr(`TCC_ADDR_VALL, 8'h00);
      wr(`TCC_ADDR_CTLA, 8'h80);
      repeat (5) begin
        i_pins.drive(1'b1);
        repeat (2) @(posedge clk);
        i_pins.drive(1'b0);
        repeat (2) @(posedge clk);
      end
      wr(`TCC_ADDR_CTLA, 8'h00);
      rdr(`TCC_ADDR_VALL);
      chk("count", rd, 16'(exp_cnt[c]));
    end
    // capture single shot: held, start edge silent, end edge captures
    for (int k = 0; k < 3; k++) begin
      i_pins.drive(k != 0);
      wr(`TCC_ADDR_CFG, {5'h0, 2'(k + 1), 1'b0});
      set16(`TCC_ADDR_VALL, 16'h0000);
      set16(`TCC_ADDR_CMPL, 16'h0000);
      wr(`TCC_ADDR_CTLB, 8'h00);
      wr(`TCC_ADDR_CTLA, {3'b010, k == 2, 4'h0});
      repeat (5) @(posedge clk);
      rdr(`TCC_ADDR_VALL);
      chk("held", rd, 0);
      i_pins.drive(k == 0);
      repeat (3) @(posedge clk);
      i_pins.drive(k != 0);
      repeat (3) @(posedge clk);
      rdr(`TCC_ADDR_CTLB);
      chk("start silent", rd & 8'h02, 0);
      i_pins.drive(k == 0);
      repeat (4) @(posedge clk);
      rdr(`TCC_ADDR_CTLB);
      chk("captured", rd & 8'h02, 8'h02);
      rdr(`TCC_ADDR_CTLA);
      chk("one cycle", rd[6], 0);
      rdr(`TCC_ADDR_CMPL);
      chk("cap value", rd != 8'h00, 1);
    end
    // gating: low level on the primary pin holds the count
    wr(`TCC_ADDR_CFG, 8'h00);
    i_pins.drive(1'b0);
    wr(`TCC_ADDR_VALL, 8'h00);
    wr(`TCC_ADDR_CTLA, 8'h81);
    repeat (5) @(posedge clk);
    rdr(`TCC_ADDR_VALL);
    chk("gated", rd, 0);
    i_pins.drive(1'b1);
    repeat (5) @(posedge clk);
    rdr(`TCC_ADDR_VALL);
    chk("ungated", rd != 8'h00, 1);
    report_and_stop();
  end
endmodule
